// ### core/ssrs_glitch_filter.sv
// glitch filter: passes a low level only after it has stood for a set number of cycles
`timescale 1ns/1ps
`default_nettype none
module ssrs_glitch_filter
	import ssrs_pkg::*;
#(
	parameter int unsigned WIDTH_CYCLES = 4
)
(
	input wire logic ref_clk, // system clock
	input wire logic arst_n, // async reset, active low
	input wire logic rawLow, // synchronised active-high "input is low"
	output logic filteredLow // active after WIDTH_CYCLES + 1 cycles of rawLow
);
	initial
	begin
		if (WIDTH_CYCLES < 1 || WIDTH_CYCLES >= (1 << FILT_W))
			$error("ssrs_glitch_filter: WIDTH_CYCLES out of range");
	end

	logic [FILT_W-1:0] count;
	logic [FILT_W-1:0] next_count;
	logic next_filteredLow;

	// release is immediate so a short high does not stretch the low
	always_comb
	begin
		next_count = '0;
		next_filteredLow = 1'b0;
		if (rawLow)
		begin
			if (count >= FILT_W'(WIDTH_CYCLES))
			begin
				next_count = count;
				next_filteredLow = 1'b1;
			end
			else
			begin
				next_count = count + FILT_W'(1);
				next_filteredLow = 1'b0;
			end
		end
	end

	always_ff @(posedge ref_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			count <= '0;
			filteredLow <= 1'b0;
		end
		else
		begin
			count <= next_count;
			filteredLow <= next_filteredLow;
		end
	end
endmodule : ssrs_glitch_filter
`default_nettype wire

// ### core/ssrs_pkg.sv
// package for the supply reset supervisor: timing constants and carrier types
package ssrs_pkg;
	// clock rate
	localparam int unsigned CLK_HZ = 125000000;
	localparam int unsigned CLK_PERIOD_PS = 8000;
	// power_up_hold_time nominal, in ms
	localparam int unsigned POWER_UP_HOLD_TIME_MS = 200;
	localparam int unsigned POWER_UP_HOLD_MIN_MS = 130;
	localparam int unsigned POWER_UP_HOLD_MAX_MS = 270;
	localparam int unsigned HOLD_CYCLES = POWER_UP_HOLD_TIME_MS * (CLK_HZ / 1000);
	// brownout_assert_delay, in us (longest time, rounds down)
	localparam int unsigned BROWNOUT_ASSERT_DELAY_US = 5;
	localparam int unsigned BROWNOUT_ASSERT_CYCLES = BROWNOUT_ASSERT_DELAY_US * (CLK_HZ / 1000000);
	// supply glitch reject width, in ns (least time, rounds up)
	localparam int unsigned SUPPLY_GLITCH_NS = 30;
	localparam int unsigned SUPPLY_GLITCH_CYCLES = (SUPPLY_GLITCH_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	// pushbutton glitch immunity, in ns
	localparam int unsigned PUSHBUTTON_GLITCH_NS = 100;
	localparam int unsigned PUSHBUTTON_GLITCH_CYCLES = (PUSHBUTTON_GLITCH_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	// pushbutton_assert_delay, in us
	localparam int unsigned PUSHBUTTON_ASSERT_DELAY_US = 1;
	localparam int unsigned PUSHBUTTON_ASSERT_CYCLES = PUSHBUTTON_ASSERT_DELAY_US * (CLK_HZ / 1000000);
	// watchdog_expiry_time nominal, in ms
	localparam int unsigned WATCHDOG_EXPIRY_TIME_MS = 1600;
	localparam longint unsigned WATCHDOG_CYCLES = 64'(WATCHDOG_EXPIRY_TIME_MS) * 64'(CLK_HZ / 1000);
	// counter widths
	localparam int unsigned HOLD_W = 28;
	localparam int unsigned WD_W = 28;
	localparam int unsigned FILT_W = 5;

	// request causes that feed the reset state: two filtered levels, a pin edge and a watchdog pulse
	typedef struct packed {
		logic supplyLow;
		logic pushbuttonLow;
		logic resetPinFall;
		logic watchdogExpired;
	} ssrs_cause_t;

	// open-drain pin drive pair
	typedef struct packed {
		logic out;
		logic oe;
	} ssrs_drive_t;

	typedef enum logic [1:0] {
		SSRS_HOLD = 2'b00,
		SSRS_TIMEOUT = 2'b01,
		SSRS_RUN = 2'b10
	} ssrs_state_t;
endpackage : ssrs_pkg

// ### core/ssrs_supervisor.sv
// supply reset supervisor: power-up, brown-out, pushbutton, reset-pin and watchdog reset control
`timescale 1ns/1ps
`default_nettype none
module ssrs_supervisor
	import ssrs_pkg::*;
#(
	parameter int unsigned HOLD_COUNT = HOLD_CYCLES,
	parameter longint unsigned WD_COUNT = WATCHDOG_CYCLES,
	parameter int unsigned SUPPLY_FILTER = SUPPLY_GLITCH_CYCLES,
	parameter int unsigned PUSH_FILTER = PUSHBUTTON_GLITCH_CYCLES
)
(
	input wire logic ref_clk, // 125 MHz timebase
	input wire logic arst_n, // async reset, active low
	input wire logic supplyBelowTrip, // comparator: supply under supply_trip_level
	input wire logic pushbutton_reset_n, // manual reset pin, active low
	input wire logic resetPinIn_n, // sensed level of the two-way reset pin
	input wire logic watchdog_toggle_input, // monitored watchdog line
	input wire logic memWriteBusy, // internal write cycle in progress
	output logic resetPinOut_n, // two-way active-low reset pin, output value
	output logic resetPinOe, // high while pulling the low pin
	output logic resetHighOut, // active-high reset pin, output value
	output logic resetHighOe, // high while driving the high pin
	output logic memAccessEnable, // memory interface may run
	output logic memAbort // one-cycle pulse: abort memory transfer
);
	initial
	begin
		if (HOLD_COUNT < 1 || HOLD_COUNT >= (1 << HOLD_W))
			$error("ssrs_supervisor: HOLD_COUNT out of range");
		if (WD_COUNT < 1 || WD_COUNT >= (64'd1 << WD_W))
			$error("ssrs_supervisor: WD_COUNT out of range");
		if (SUPPLY_FILTER > BROWNOUT_ASSERT_CYCLES - 4)
			$error("ssrs_supervisor: SUPPLY_FILTER exceeds brownout delay");
		if (PUSH_FILTER > PUSHBUTTON_ASSERT_CYCLES - 4)
			$error("ssrs_supervisor: PUSH_FILTER exceeds pushbutton delay");
	end

	// two-flop synchronisers for all pin inputs
	logic [3:0] syncA;
	logic [3:0] syncB;
	logic [3:0] next_syncA;
	logic [3:0] next_syncB;
	logic pinPrev;
	logic next_pinPrev;
	logic wdPrev;
	logic next_wdPrev;

	always_comb
	begin
		next_syncA = {watchdog_toggle_input, resetPinIn_n, pushbutton_reset_n, supplyBelowTrip};
		next_syncB = syncA;
		next_pinPrev = syncB[2];
		next_wdPrev = syncB[3];
	end

	// pins idle high; supply is taken as low until the comparator says otherwise
	always_ff @(posedge ref_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			syncA <= 4'hf;
			syncB <= 4'hf;
			pinPrev <= 1'b1;
			wdPrev <= 1'b1;
		end
		else
		begin
			syncA <= next_syncA;
			syncB <= next_syncB;
			pinPrev <= next_pinPrev;
			wdPrev <= next_wdPrev;
		end
	end

	ssrs_cause_t cause;
	logic supplyFiltered;
	logic pushFiltered;

	ssrs_glitch_filter #(
		.WIDTH_CYCLES(SUPPLY_FILTER)
	) u_supplyFilter (
		.ref_clk(ref_clk),
		.arst_n(arst_n),
		.rawLow(syncB[0]),
		.filteredLow(supplyFiltered)
	);

	ssrs_glitch_filter #(
		.WIDTH_CYCLES(PUSH_FILTER)
	) u_pushFilter (
		.ref_clk(ref_clk),
		.arst_n(arst_n),
		.rawLow(~syncB[1]),
		.filteredLow(pushFiltered)
	);

	// the pin edge is taken only while released, so our own pull-down cannot retrigger
	logic resetActive;
	logic wdExpired;

	always_comb
	begin
		cause.supplyLow = supplyFiltered;
		cause.pushbuttonLow = pushFiltered;
		cause.resetPinFall = pinPrev & ~syncB[2] & ~resetActive;
		cause.watchdogExpired = wdExpired;
	end

	// reset state machine
	ssrs_state_t state;
	ssrs_state_t next_state;
	logic [HOLD_W-1:0] holdCount;
	logic [HOLD_W-1:0] next_holdCount;

	always_comb
	begin
		next_state = state;
		next_holdCount = holdCount;
		unique case (state)
			SSRS_HOLD:
			begin
				next_holdCount = '0;
				// held while a level cause stays active
				if (!cause.supplyLow && !cause.pushbuttonLow)
					next_state = SSRS_TIMEOUT;
			end
			SSRS_TIMEOUT:
			begin
				if (cause.supplyLow || cause.pushbuttonLow)
				begin
					next_state = SSRS_HOLD;
					next_holdCount = '0;
				end
				else if (holdCount >= HOLD_W'(HOLD_COUNT - 1))
				begin
					next_state = SSRS_RUN;
					next_holdCount = '0;
				end
				else
					next_holdCount = holdCount + HOLD_W'(1);
			end
			SSRS_RUN:
			begin
				next_holdCount = '0;
				if (cause.supplyLow || cause.pushbuttonLow)
					next_state = SSRS_HOLD;
				else if (cause.resetPinFall || cause.watchdogExpired)
					next_state = SSRS_TIMEOUT;
			end
			default:
			begin
				next_state = SSRS_HOLD;
				next_holdCount = '0;
			end
		endcase
	end

	always_ff @(posedge ref_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			state <= SSRS_HOLD;
			holdCount <= '0;
		end
		else
		begin
			state <= next_state;
			holdCount <= next_holdCount;
		end
	end

	assign resetActive = (state != SSRS_RUN);

	// watchdog counter
	logic [WD_W-1:0] wdCount;
	logic [WD_W-1:0] next_wdCount;
	logic next_wdExpired;

	always_comb
	begin
		next_wdCount = wdCount;
		next_wdExpired = 1'b0;
		if (resetActive || (wdPrev != syncB[3]))
			next_wdCount = '0;
		else if (wdCount >= WD_W'(WD_COUNT - 1))
		begin
			next_wdCount = '0;
			next_wdExpired = 1'b1;
		end
		else
			next_wdCount = wdCount + WD_W'(1);
	end

	always_ff @(posedge ref_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			wdCount <= '0;
			wdExpired <= 1'b0;
		end
		else
		begin
			wdCount <= next_wdCount;
			wdExpired <= next_wdExpired;
		end
	end

	// outputs, registered from the one reset state; memAbort is also gated by memAccessEnable and memWriteBusy
	ssrs_drive_t lowDrive;
	ssrs_drive_t highDrive;
	ssrs_drive_t next_lowDrive;
	ssrs_drive_t next_highDrive;
	logic next_memAccessEnable;
	logic next_memAbort;

	always_comb
	begin
		next_lowDrive.out = 1'b0;
		next_lowDrive.oe = resetActive;
		next_highDrive.out = 1'b1;
		next_highDrive.oe = resetActive;
		// a running internal write is left to finish; only the bus side is cut
		next_memAccessEnable = ~resetActive;
		next_memAbort = resetActive & memAccessEnable & ~memWriteBusy;
	end

	always_ff @(posedge ref_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			lowDrive <= '{out: 1'b0, oe: 1'b1};
			highDrive <= '{out: 1'b1, oe: 1'b1};
			memAccessEnable <= 1'b0;
			memAbort <= 1'b0;
		end
		else
		begin
			lowDrive <= next_lowDrive;
			highDrive <= next_highDrive;
			memAccessEnable <= next_memAccessEnable;
			memAbort <= next_memAbort;
		end
	end

	assign resetPinOut_n = lowDrive.out;
	assign resetPinOe = lowDrive.oe;
	assign resetHighOut = highDrive.out;
	assign resetHighOe = highDrive.oe;
endmodule : ssrs_supervisor
`default_nettype wire

// ### verif/ssrs_far_side.sv
// far side model: reset wires with pull resistors, outside reset source and pushbutton
`timescale 1ns/1ps
`default_nettype none
module ssrs_far_side
(
	input wire logic resetPinOut_n, // device low-pin value
	input wire logic resetPinOe, // device low-pin enable
	input wire logic resetHighOut, // device high-pin value
	input wire logic resetHighOe, // device high-pin enable
	input wire logic extResetReq, // outside source pulls the line low
	input wire logic buttonPressed, // switch closed to ground
	output logic resetLine_n, // resolved active-low wire
	output logic resetHigh, // resolved active-high wire
	output logic pushbutton_reset_n // button pin level
);
	// released lines fall back to their pull resistors
	assign resetLine_n = ((resetPinOe && !resetPinOut_n) || extResetReq) ? 1'b0 : 1'b1;
	assign resetHigh = resetHighOe ? resetHighOut : 1'b0;
	assign pushbutton_reset_n = !buttonPressed;
endmodule : ssrs_far_side
`default_nettype wire

// ### verif/ssrs_supervisor_properties.sv
// checker: port-level properties of the supply reset supervisor
`timescale 1ns/1ps
`default_nettype none
module ssrs_checker
	import ssrs_pkg::*;
#(
	parameter int unsigned HOLD_COUNT = 20,
	parameter longint unsigned WD_COUNT = 50
)
(
	input wire logic ref_clk, // clock
	input wire logic arst_n, // reset
	input wire logic supplyBelowTrip, // supply low
	input wire logic pushbutton_reset_n, // button
	input wire logic resetPinIn_n, // pin sense
	input wire logic watchdog_toggle_input, // watchdog
	input wire logic memWriteBusy, // write busy
	input wire logic resetPinOut_n, // pin value
	input wire logic resetPinOe, // pin enable
	input wire logic resetHighOut, // high value
	input wire logic resetHighOe, // high enable
	input wire logic memAccessEnable, // mem enable
	input wire logic memAbort // abort pulse
);
	longint unsigned oeRun, quiet, wdCnt, pbCnt;
	longint unsigned next_oeRun, next_quiet, next_wdCnt, next_pbCnt;
	logic wdPrev;
	always_comb
	begin
		next_oeRun = resetPinOe ? oeRun + 1 : 0;
		// quiet: reset driven with no level cause left
		next_quiet = (resetPinOe && !supplyBelowTrip && pushbutton_reset_n) ? quiet + 1 : 0;
		next_wdCnt = (resetPinOe || watchdog_toggle_input != wdPrev) ? 0 : wdCnt + 1;
		next_pbCnt = pushbutton_reset_n ? 0 : pbCnt + 1;
	end
	always_ff @(posedge ref_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			oeRun <= 0;
			quiet <= 0;
			wdCnt <= 0;
			pbCnt <= 0;
			wdPrev <= 1'b0;
		end
		else
		begin
			oeRun <= next_oeRun;
			quiet <= next_quiet;
			wdCnt <= next_wdCnt;
			pbCnt <= next_pbCnt;
			wdPrev <= watchdog_toggle_input;
		end
	end
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!arst_n);
	property p_pair; resetPinOe == resetHighOe; endproperty
	a_pair: assert property (p_pair) else $error("reset enables differ");
	property p_od; resetPinOut_n == 1'b0 && resetHighOut == 1'b1; endproperty
	a_od: assert property (p_od) else $error("open-drain value wrong");
	property p_brown; supplyBelowTrip [*6] |-> ##[0:619] resetPinOe; endproperty
	a_brown: assert property (p_brown) else $error("brownout reset late");
	property p_glitch;
		(!resetPinOe && !supplyBelowTrip && pushbutton_reset_n && resetPinIn_n) ##1 supplyBelowTrip [*3]
			##1 !supplyBelowTrip |-> !resetPinOe [*8];
	endproperty
	a_glitch: assert property (p_glitch) else $error("supply glitch caused reset");
	property p_push; pbCnt == 14 |-> ##[0:111] resetPinOe; endproperty
	a_push: assert property (p_push) else $error("button reset late");
	property p_hold; $fell(resetPinOe) |-> oeRun >= HOLD_COUNT; endproperty
	a_hold: assert property (p_hold) else $error("reset too short");
	property p_release; quiet <= HOLD_COUNT + 24; endproperty
	a_release: assert property (p_release) else $error("reset not released");
	property p_pin; (!resetPinOe && $fell(resetPinIn_n)) |-> ##[1:6] resetPinOe; endproperty
	a_pin: assert property (p_pin) else $error("pin edge missed");
	property p_wd; wdCnt <= WD_COUNT + 8; endproperty
	a_wd: assert property (p_wd) else $error("watchdog expiry missed");
	property p_mem; resetPinOe |-> !memAccessEnable; endproperty
	a_mem: assert property (p_mem) else $error("memory open in reset");
	property p_abort; memAbort |-> resetPinOe ##1 !memAbort; endproperty
	a_abort: assert property (p_abort) else $error("abort pulse wrong");
	c_push: cover property (pbCnt == 14);
	c_fall: cover property ($fell(resetPinOe));
	c_abort: cover property (memAbort);
endmodule : ssrs_checker
bind ssrs_supervisor ssrs_checker #(.HOLD_COUNT(HOLD_COUNT), .WD_COUNT(WD_COUNT)) i_chk (.ref_clk(ref_clk),
	.arst_n(arst_n), .supplyBelowTrip(supplyBelowTrip), .pushbutton_reset_n(pushbutton_reset_n),
	.resetPinIn_n(resetPinIn_n), .watchdog_toggle_input(watchdog_toggle_input), .memWriteBusy(memWriteBusy),
	.resetPinOut_n(resetPinOut_n), .resetPinOe(resetPinOe), .resetHighOut(resetHighOut),
	.resetHighOe(resetHighOe), .memAccessEnable(memAccessEnable), .memAbort(memAbort));
`default_nettype wire

// ### verif/testbench.sv
// self-checking testbench for the supply reset supervisor
`timescale 1ns/1ps
`default_nettype none
module testbench;
	import ssrs_pkg::*;
	localparam int HOLD = 20;
	localparam int WD = 50;
	logic ref_clk, arst_n, supplyBelowTrip, wdToggle, memWriteBusy, ext, btn, wdRun, abortSeen;
	logic resetPinOut_n, resetPinOe, resetHighOut, resetHighOe, memAccessEnable, memAbort;
	logic resetLine_n, resetHigh, pushbutton_reset_n;
	int n_fail, comparisons;
	ssrs_supervisor #(.HOLD_COUNT(HOLD), .WD_COUNT(WD)) i_dut (.ref_clk(ref_clk), .arst_n(arst_n),
		.supplyBelowTrip(supplyBelowTrip), .pushbutton_reset_n(pushbutton_reset_n), .resetPinIn_n(resetLine_n),
		.watchdog_toggle_input(wdToggle), .memWriteBusy(memWriteBusy), .resetPinOut_n(resetPinOut_n),
		.resetPinOe(resetPinOe), .resetHighOut(resetHighOut), .resetHighOe(resetHighOe),
		.memAccessEnable(memAccessEnable), .memAbort(memAbort));
	ssrs_far_side i_far (.resetPinOut_n(resetPinOut_n), .resetPinOe(resetPinOe), .resetHighOut(resetHighOut),
		.resetHighOe(resetHighOe), .extResetReq(ext), .buttonPressed(btn), .resetLine_n(resetLine_n),
		.resetHigh(resetHigh), .pushbutton_reset_n(pushbutton_reset_n));
	task automatic finish_test;
		$display("comparisons %0d mismatches %0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : finish_test
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp)
		begin
			n_fail++;
			$display("mismatch at %0t: saw %0h expected %0h", $time, seen, exp);
		end
	endtask : check
	task automatic tick(input int k);
		repeat (k) @(posedge ref_clk);
		#1;
	endtask : tick
	// counts cycles until the reset enable reaches lvl, capped
	task automatic waitOe(input logic lvl, input int cap, output int n);
		n = 0;
		while (resetPinOe !== lvl && n < cap)
		begin
			tick(1);
			n++;
		end
	endtask : waitOe
	task automatic t_powerup;
		int n;
		tick(10);
		check(resetPinOe, 1'b1);
		check(memAccessEnable, 1'b0);
		supplyBelowTrip = 1'b0;
		waitOe(1'b0, 200, n);
		check(n >= HOLD && n <= HOLD + 12, 1'b1);
		check({resetLine_n, resetHigh, memAccessEnable}, 3'b101);
	endtask : t_powerup
	task automatic t_supply;
		int n;
		// start the glitch from a released, settled state
		tick(2);
		supplyBelowTrip = 1'b1;
		tick(3);
		supplyBelowTrip = 1'b0;
		tick(20);
		check(resetPinOe, 1'b0);
		supplyBelowTrip = 1'b1;
		waitOe(1'b1, 625, n);
		check(n < 625, 1'b1);
		tick(40);
		check(resetHigh, 1'b1);
		supplyBelowTrip = 1'b0;
		waitOe(1'b0, 200, n);
		check(n >= HOLD, 1'b1);
	endtask : t_supply
	task automatic t_push;
		int n;
		btn = 1'b1;
		tick(12);
		btn = 1'b0;
		tick(20);
		check(resetPinOe, 1'b0);
		// watchdog silent across a hold longer than its expiry
		wdRun = 1'b0;
		btn = 1'b1;
		waitOe(1'b1, 125, n);
		check(n < 125, 1'b1);
		tick(80);
		check(resetLine_n, 1'b0);
		btn = 1'b0;
		waitOe(1'b0, 200, n);
		check(n >= HOLD, 1'b1);
		tick(WD - 10);
		check(resetPinOe, 1'b0);
		waitOe(1'b1, 30, n);
		check(resetPinOe, 1'b1);
		wdRun = 1'b1;
		waitOe(1'b0, 200, n);
		check(n >= HOLD, 1'b1);
	endtask : t_push
	task automatic t_pin;
		int n;
		for (int b = 0; b < 2; b++)
		begin
			// the released pin must be seen high first, or no falling edge exists
			tick(5);
			memWriteBusy = b[0];
			abortSeen = 1'b0;
			ext = 1'b1;
			tick(2);
			ext = 1'b0;
			waitOe(1'b1, 6, n);
			check(n < 6, 1'b1);
			waitOe(1'b0, 200, n);
			check(n >= HOLD, 1'b1);
			check(abortSeen, !b[0]);
		end
		memWriteBusy = 1'b0;
	endtask : t_pin
	always @(posedge ref_clk)
		if (memAbort === 1'b1)
			abortSeen <= 1'b1;
	always
	begin
		tick(10);
		if (wdRun)
			wdToggle = !wdToggle;
	end
	initial
	begin
		ref_clk = 1'b0;
		forever #4 ref_clk = ~ref_clk;
	end
	initial
	begin
		#200000;
		n_fail++;
		finish_test;
	end
	initial
	begin
		{arst_n, ext, btn, wdToggle, memWriteBusy, abortSeen} = 6'h00;
		supplyBelowTrip = 1'b1;
		wdRun = 1'b1;
		n_fail = 0;
		comparisons = 0;
		tick(6);
		arst_n = 1'b1;
		t_powerup;
		t_supply;
		t_push;
		t_pin;
		finish_test;
	end
endmodule : testbench
`default_nettype wire
